// ---- toc_pkg.sv ----
// package of constants and carrier types for the tia offset/gain correction
package toc_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_LOCK      = 16'h2230; // calibration_lock_key
	localparam logic [15:0] ADDR_HS_OFFSET = 16'h2234; // hs_tia_offset_cal
	localparam logic [15:0] ADDR_HS_GAIN   = 16'h2284; // hs_tia_gain_cal
	localparam logic [15:0] ADDR_LP_OFFSET = 16'h2288; // lp_tia_offset_cal
	localparam logic [15:0] ADDR_LP_GAIN   = 16'h228C; // lp_tia_gain_cal

	// ------------------------------------------------------------
	// field layout and reset values
	// ------------------------------------------------------------
	localparam int          CAL_W        = 15;           // value field width
	localparam logic [31:0] UNLOCK_KEY   = 32'hDE87A5AF; // unlock key
	localparam logic [14:0] OFFSET_RST   = 15'h0000;     // no correction
	localparam logic [14:0] GAIN_RST     = 15'h4000;     // unity gain
	localparam logic [14:0] GAIN_ILLEGAL = 15'h0000;     // forces zero
	localparam int          GAIN_FRAC    = 14;           // gain fraction bits
	localparam int          OFS_FRAC     = 2;            // offset fraction bits
	localparam logic [15:0] RES_MAX      = 16'h7FFF;     // saturate high
	localparam logic [15:0] RES_MIN      = 16'h8000;     // saturate low

	// ------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------
	typedef enum logic [0:0] {
		TOC_CH_LP = 1'b0, // low power tia
		TOC_CH_HS = 1'b1  // high speed tia
	} toc_chan_t;

	typedef struct packed {
		logic [14:0] offset; // twos complement quarter-lsb
		logic [14:0] gain;   // unsigned, unity at 0x4000
	} toc_cal_t;

	typedef struct packed {
		logic        valid;  // result present
		toc_chan_t   chan;   // source channel
		logic [15:0] data;   // signed adc result word
	} toc_sample_t;

endpackage : toc_pkg

// ---- toc_correct.sv ----
// offset and gain correction of tia adc results with register port
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module toc_correct (
	// clock and reset
	input  wire logic                 mclk_i,
	input  wire logic                 nrst_i,
	// register port
	input  wire logic [15:0]          addr_i,
	input  wire logic [31:0]          wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output var  logic [31:0]          rdata_o,
	// raw result in
	input  wire toc_pkg::toc_sample_t raw_i,
	// corrected result out
	output var  toc_pkg::toc_sample_t adc_result_word_o
);

	// ------------------------------------------------------------
	// decode helper
	// ------------------------------------------------------------
	// one-hot map of the address onto the five registers
	function automatic logic [4:0] decode(input logic [15:0] a);
		logic [4:0] d;
		d = 5'h00;
		if (a == toc_pkg::ADDR_LOCK) begin
			d[0] = 1'b1;
		end else if (a == toc_pkg::ADDR_HS_OFFSET) begin
			d[1] = 1'b1;
		end else if (a == toc_pkg::ADDR_HS_GAIN) begin
			d[2] = 1'b1;
		end else if (a == toc_pkg::ADDR_LP_OFFSET) begin
			d[3] = 1'b1;
		end else if (a == toc_pkg::ADDR_LP_GAIN) begin
			d[4] = 1'b1;
		end
		return d;
	endfunction : decode

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [31:0]       lock_key;      // last key written
	logic [31:0]       next_lock_key;
	toc_pkg::toc_cal_t cal_lp;        // low power pair
	toc_pkg::toc_cal_t next_cal_lp;
	toc_pkg::toc_cal_t cal_hs;        // high speed pair
	toc_pkg::toc_cal_t next_cal_hs;
	logic [31:0]       next_rdata;
	logic [4:0]        sel;           // decoded address
	logic              unlocked;      // key matches

	// next values of the register file
	always_comb begin
		sel           = decode(addr_i);
		unlocked      = (lock_key == toc_pkg::UNLOCK_KEY);
		next_lock_key = lock_key;
		next_cal_lp   = cal_lp;
		next_cal_hs   = cal_hs;
		next_rdata    = 32'h00000000;
		if (wr_i) begin
			// key register always writable, so software can relock
			if (sel[0]) begin
				next_lock_key = wdata_i;
			end
			// calibration writes dropped while locked
			if (unlocked) begin
				if (sel[1]) begin
					next_cal_hs.offset = wdata_i[14:0];
				end
				if (sel[2]) begin
					next_cal_hs.gain = wdata_i[14:0];
				end
				if (sel[3]) begin
					next_cal_lp.offset = wdata_i[14:0];
				end
				if (sel[4]) begin
					next_cal_lp.gain = wdata_i[14:0];
				end
			end
		end
		// read data; reserved bits 31:15 read as zero
		if (rd_i) begin
			if (sel[0]) begin
				next_rdata = lock_key;
			end else if (sel[1]) begin
				next_rdata = {17'h00000, cal_hs.offset};
			end else if (sel[2]) begin
				next_rdata = {17'h00000, cal_hs.gain};
			end else if (sel[3]) begin
				next_rdata = {17'h00000, cal_lp.offset};
			end else if (sel[4]) begin
				next_rdata = {17'h00000, cal_lp.gain};
			end
		end
	end

	// register file flops
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			lock_key      <= 32'h00000000;
			cal_lp.offset <= toc_pkg::OFFSET_RST;
			cal_hs.offset <= toc_pkg::OFFSET_RST;
			cal_lp.gain   <= toc_pkg::GAIN_RST;
			cal_hs.gain   <= toc_pkg::GAIN_RST;
			rdata_o       <= 32'h00000000;
		end else begin
			lock_key <= next_lock_key;
			cal_lp   <= next_cal_lp;
			cal_hs   <= next_cal_hs;
			rdata_o  <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// correction datapath
	// ------------------------------------------------------------
	toc_pkg::toc_cal_t   pair;      // pair for this sample
	logic signed [18:0]  diff_q;    // result minus offset, quarter lsb
	logic signed [34:0]  prod;      // diff times gain
	logic signed [34:0]  scaled;    // back to result lsb
	toc_pkg::toc_sample_t next_out;

	// one-cycle pipeline: select, subtract, multiply, saturate
	always_comb begin
		// pick the pair of the converted channel
		pair = (raw_i.chan == toc_pkg::TOC_CH_HS) ? cal_hs : cal_lp;
		// result shifted up two bits so offset lsb is a quarter
		diff_q = {{1{raw_i.data[15]}}, raw_i.data, 2'b00}
			- {{4{pair.offset[14]}}, pair.offset};
		// unsigned gain, 14 fraction bits: linear, step 2^-14
		prod = 35'(diff_q) * $signed({1'b0, pair.gain});
		// drop gain fraction and the two offset fraction bits
		scaled = prod >>> (toc_pkg::GAIN_FRAC + toc_pkg::OFS_FRAC);
		next_out       = raw_i;
		next_out.valid = raw_i.valid;
		if (pair.gain == toc_pkg::GAIN_ILLEGAL) begin
			next_out.data = 16'h0000;
		end else if (scaled > 35'sd32767) begin
			next_out.data = toc_pkg::RES_MAX;
		end else if (scaled < -35'sd32768) begin
			next_out.data = toc_pkg::RES_MIN;
		end else begin
			next_out.data = scaled[15:0];
		end
	end

	// output flops
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			adc_result_word_o <= '0;
		end else begin
			adc_result_word_o <= next_out;
		end
	end

endmodule : toc_correct

`default_nettype wire

// ---- toc_correct_sva.sv ----
// port checker for the tia correction block
`timescale 1ns/1ps
`default_nettype none
module toc_correct_sva (
	input wire logic [15:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [31:0] rdata_o,
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire toc_pkg::toc_sample_t raw_i,
	input wire toc_pkg::toc_sample_t adc_result_word_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	// key write, then lp offset write and read back to back
	sequence key_wr;
		wr_i && addr_i == 16'h2230 && wdata_i == toc_pkg::UNLOCK_KEY;
	endsequence
	sequence ofs_wr_rd;
		wr_i && addr_i == 16'h2288 ##1 rd_i && addr_i == 16'h2288;
	endsequence
	valid_pipe_a: assert property (raw_i.valid |=> adc_result_word_o.valid)
		else $error("result valid missing");
	no_valid_a: assert property (!raw_i.valid |=> !adc_result_word_o.valid)
		else $error("result valid unasked");
	chan_keep_a: assert property (raw_i.valid |=>
		adc_result_word_o.chan == $past(raw_i.chan)) else $error("chan lost");
	resv_zero_a: assert property (rd_i && addr_i != 16'h2230 |=>
		rdata_o[31:15] == 17'h0) else $error("reserved bits set");
	unlk_wr_a: assert property (key_wr ##1 ofs_wr_rd |=>
		rdata_o[14:0] == $past(wdata_i[14:0], 2)) else $error("unlocked write");
	key_back_a: assert property (wr_i && addr_i == 16'h2230 ##1 rd_i
		&& addr_i == 16'h2230 |=> rdata_o == $past(wdata_i, 2))
		else $error("lock readback");
	unmap_rd_a: assert property (rd_i && addr_i == 16'h1000 |=>
		rdata_o == 32'h0) else $error("unmapped read");
	rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data not idle");
endmodule : toc_correct_sva
bind toc_correct toc_correct_sva u_sva (.mclk_i(mclk_i), .nrst_i(nrst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .raw_i(raw_i), .adc_result_word_o(adc_result_word_o));
`default_nettype wire

// ---- tb_tia_adc_offset_gain_correction.sv ----
// self-checking bench of the tia offset and gain correction
`timescale 1ns/1ps
`default_nettype none
module tb_tia_adc_offset_gain_correction;
	logic mclk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic [15:0] addr_i = 16'h0;
	logic [31:0] wdata_i = 32'h0, rdata_o;
	toc_pkg::toc_sample_t raw_i = '0, adc_result_word_o;
	int miscompares = 0, check_count = 0;
	always #5 mclk_i = ~mclk_i;
	toc_correct dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.raw_i(raw_i), .adc_result_word_o(adc_result_word_o));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge mclk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, v};
		@(posedge mclk_i) wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		@(posedge mclk_i) {rd_i, addr_i} <= {1'b1, a};
		@(posedge mclk_i) rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask : rd
	// model: quarter-lsb offset off, gain with 14 fraction bits, floor
	function automatic logic [15:0] exp_f(input logic [15:0] dv,
		input logic [14:0] o, input logic [14:0] g);
		logic signed [40:0] p;
		p = ($signed({dv[15], dv, 2'b00}) - $signed({{4{o[14]}}, o}))
			* $signed({1'b0, g});
		p = p >>> 16;
		if (g == 15'h0) return 16'h0;
		if (p > 41'sd32767) return 16'h7FFF;
		if (p < -41'sd32768) return 16'h8000;
		return p[15:0];
	endfunction : exp_f
	task automatic t_reset();
		repeat (12) @(posedge mclk_i);
		nrst_i <= 1'b1;
		rd(16'h2234, 32'h0);
		rd(16'h2284, 32'h4000);
		rd(16'h2288, 32'h0);
		rd(16'h228C, 32'h4000);
		rd(16'h1000, 32'h0);
	endtask : t_reset
	task automatic t_lock();
		wr(16'h2288, 32'h5);
		rd(16'h2288, 32'h0);
		@(posedge mclk_i) {wr_i, addr_i, wdata_i} <= {1'b1, 16'h2230, 32'hDE87A5AF};
		@(posedge mclk_i) {addr_i, wdata_i} <= {16'h2288, 32'hFFFFFFFF};
		@(posedge mclk_i) {wr_i, rd_i} <= 2'b01;
		@(posedge mclk_i) {wr_i, rd_i, addr_i, wdata_i} <= {2'b10, 16'h2230, 32'h0};
		#1 chk(rdata_o, 32'h7FFF);
		@(posedge mclk_i) {wr_i, rd_i} <= 2'b01;
		@(posedge mclk_i) rd_i <= 1'b0;
		#1 chk(rdata_o, 32'h0);
		wr(16'h2288, 32'h1);
		rd(16'h2288, 32'h7FFF);
	endtask : t_lock
	task automatic t_math();
		logic [14:0] ofs [7] = '{15'h4, 15'h4000, 15'h7FFF, 15'h1, 15'h0, 15'h0, 15'h3FFF};
		logic [14:0] gn [7] = '{15'h4000, 15'h4000, 15'h4001, 15'h2000, 15'h7FFF, 15'h0, 15'h3FFF};
		logic [15:0] dat [7] = '{16'h64, 16'h0, 16'h3E8, 16'h3E8, 16'h7000, 16'h4D2, 16'h8000};
		logic [6:0] chs = 7'h38;
		wr(16'h2230, 32'hDE87A5AF);
		for (int i = 0; i < 7; i++) begin
			wr(chs[i] ? 16'h2234 : 16'h2288, {17'h0, ofs[i]});
			wr(chs[i] ? 16'h2284 : 16'h228C, {17'h0, gn[i]});
			@(posedge mclk_i) raw_i <= {1'b1, chs[i], dat[i]};
			@(posedge mclk_i) raw_i.valid <= 1'b0;
			#1 chk(adc_result_word_o, {1'b1, chs[i], exp_f(dat[i], ofs[i], gn[i])});
		end
	endtask : t_math
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim
	initial begin
		t_reset();
		t_lock();
		t_math();
		end_sim();
	end
endmodule : tb_tia_adc_offset_gain_correction
`default_nettype wire
